/* File: core/vrs_pkg.sv */
// Package: register map, field layout and carrier types of the reference bank
package vrs_pkg;

   // ---------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [5:0] VRS_IDX_CONV_IN  = 6'h00;
   localparam logic [5:0] VRS_IDX_CONV_OUT = 6'h02;
   localparam logic [5:0] VRS_IDX_COMP     = 6'h04;
   localparam logic [5:0] VRS_IDX_STATUS   = 6'h06;
   localparam int         VRS_ADDR_LSB     = 2;

   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int         VRS_KEEP_ON_BIT  = 7;
   localparam int         VRS_LEVEL_MSB    = 2;
   localparam int         VRS_STAT_REQ_LSB = 4;
   localparam logic [7:0] VRS_CTRL_RESET   = 8'h00;
   localparam int         VRS_NUM_SRC      = 3;
   localparam int         VRS_SRC_IN       = 0;
   localparam int         VRS_SRC_OUT      = 1;
   localparam int         VRS_SRC_CMP      = 2;

   // ---------------------------------------------------------------
   // Level-select codes
   // ---------------------------------------------------------------
   localparam logic [2:0] VRS_LEVEL_1_024   = 3'h0;
   localparam logic [2:0] VRS_LEVEL_2_048   = 3'h1;
   localparam logic [2:0] VRS_LEVEL_4_096   = 3'h2;
   localparam logic [2:0] VRS_LEVEL_2_500   = 3'h3;
   localparam logic [2:0] VRS_LEVEL_RSV4    = 3'h4;
   localparam logic [2:0] VRS_LEVEL_SUPPLY  = 3'h5;
   localparam logic [2:0] VRS_LEVEL_EXT_PIN = 3'h6;
   localparam logic [2:0] VRS_LEVEL_RSV7    = 3'h7;

   // ---------------------------------------------------------------
   // Bus responses
   // ---------------------------------------------------------------
   localparam logic [1:0] VRS_RESP_OKAY   = 2'h0;
   localparam logic [1:0] VRS_RESP_SLVERR = 2'h2;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic       keep_on;
      logic [3:0] unused;
      logic [2:0] level_select;
   } vrs_ctrl_t;

   typedef struct packed {
      logic       enable;
      logic [2:0] level_select;
      logic       internal;
      logic       supply;
      logic       external_ref_pin;
   } vrs_route_t;

   typedef enum logic [2:0] {
      VRS_SEL_IN,
      VRS_SEL_OUT,
      VRS_SEL_CMP,
      VRS_SEL_STAT,
      VRS_SEL_NONE
   } vrs_sel_t;

endpackage

/* File: core/vrs_ref_channel.sv */
// One reference source: enable and routing decode, registered outputs
module vrs_ref_channel
   import vrs_pkg::*;
(
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       reset_n,
   // Control
   input  vrs_ctrl_t       ctrl,
   input  wire logic       request,
   // Analog control
   output vrs_route_t      route
);

   // ---------------------------------------------------------------
   // Route decode
   // ---------------------------------------------------------------
   vrs_route_t next_route;

   always_comb
   begin
      next_route                  = '0;
      next_route.enable           = ctrl.keep_on | request;
      next_route.level_select     = ctrl.level_select;
      // Reserved codes leave every route off
      next_route.internal         = (ctrl.level_select <= VRS_LEVEL_2_500);
      next_route.supply           = (ctrl.level_select == VRS_LEVEL_SUPPLY);
      next_route.external_ref_pin = (ctrl.level_select == VRS_LEVEL_EXT_PIN);
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         route <= '0;
      else
         route <= next_route;
   end

endmodule

/* File: core/vrs_regs.sv */
// Reference-select register bank with AXI4-Lite slave
// Operation
// - Keep-on clear: source enabled only while its consumer requests it.
// - Keep-on set: source held enabled regardless of requests.
// - Converter-input level codes 0..3 pick 1.024, 2.048, 4.096, 2.500 V.
// - Code 5 routes supply, code 6 routes external reference pin.
// - Converter-output register has own keep-on and level, same encoding.
// - Comparator register drives one source shared by all comparators.
// - Converter-input keep-on affects only the converter-input source.
// - Sources switch on when requested, off when unused, unless kept on.
module vrs_regs
   import vrs_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              reset_n,
   // AXI4-Lite write address
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   // AXI4-Lite write data
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   // AXI4-Lite write response
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   output logic [1:0]             s_axi_bresp,
   // AXI4-Lite read address
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   // AXI4-Lite read data
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   // Consumer requests
   input  wire logic              converter_input_req,
   input  wire logic              converter_output_req,
   input  wire logic              comparators_req,
   // Reference source controls
   output vrs_route_t             converter_input_ref,
   output vrs_route_t             converter_output_ref,
   output vrs_route_t             comparators_ref
);

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   // Word addressing only: the low two address bits are ignored.
   function automatic vrs_sel_t decode_sel(input logic [ADDR_W-1:0] addr);
      logic [ADDR_W-1:0] idx;
      idx = addr >> VRS_ADDR_LSB;
      if (idx == ADDR_W'(VRS_IDX_CONV_IN))
         decode_sel = VRS_SEL_IN;
      else if (idx == ADDR_W'(VRS_IDX_CONV_OUT))
         decode_sel = VRS_SEL_OUT;
      else if (idx == ADDR_W'(VRS_IDX_COMP))
         decode_sel = VRS_SEL_CMP;
      else if (idx == ADDR_W'(VRS_IDX_STATUS))
         decode_sel = VRS_SEL_STAT;
      else
         decode_sel = VRS_SEL_NONE;
   endfunction

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   vrs_ctrl_t                  ctrl [VRS_NUM_SRC];
   vrs_route_t                 route [VRS_NUM_SRC];
   logic [VRS_NUM_SRC-1:0]     request;

   logic                       aw_held;
   logic                       w_held;
   logic [ADDR_W-1:0]          aw_addr;
   logic [7:0]                 w_byte;
   logic                       w_lane0;
   logic                       do_write;
   vrs_sel_t                   wr_sel;
   vrs_sel_t                   rd_sel;
   logic [31:0]                next_rdata;

   assign request[VRS_SRC_IN]  = converter_input_req;
   assign request[VRS_SRC_OUT] = converter_output_req;
   assign request[VRS_SRC_CMP] = comparators_req;

   // ---------------------------------------------------------------
   // Write channels
   // ---------------------------------------------------------------
   // One write in flight; address and data are accepted in any order.
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign do_write      = aw_held && w_held && !s_axi_bvalid;
   assign wr_sel        = decode_sel(aw_addr);

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end
      else if (do_write)
         aw_held <= 1'b0;
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         w_held  <= 1'b0;
         w_byte  <= 8'h00;
         w_lane0 <= 1'b0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_held  <= 1'b1;
         w_byte  <= s_axi_wdata[7:0];
         w_lane0 <= s_axi_wstrb[0];
      end
      else if (do_write)
         w_held <= 1'b0;
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= VRS_RESP_OKAY;
      end
      else if (do_write)
      begin
         s_axi_bvalid <= 1'b1;
         if (wr_sel == VRS_SEL_NONE || wr_sel == VRS_SEL_STAT)
            s_axi_bresp <= VRS_RESP_SLVERR;
         else
            s_axi_bresp <= VRS_RESP_OKAY;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   // Bits 6:3 are not stored; they always read back as zero.
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctrl[VRS_SRC_IN]  <= VRS_CTRL_RESET;
         ctrl[VRS_SRC_OUT] <= VRS_CTRL_RESET;
         ctrl[VRS_SRC_CMP] <= VRS_CTRL_RESET;
      end
      else if (do_write && w_lane0)
      begin
         if (wr_sel == VRS_SEL_IN)
         begin
            ctrl[VRS_SRC_IN].keep_on      <= w_byte[VRS_KEEP_ON_BIT];
            ctrl[VRS_SRC_IN].level_select <= w_byte[VRS_LEVEL_MSB:0];
         end
         else if (wr_sel == VRS_SEL_OUT)
         begin
            ctrl[VRS_SRC_OUT].keep_on      <= w_byte[VRS_KEEP_ON_BIT];
            ctrl[VRS_SRC_OUT].level_select <= w_byte[VRS_LEVEL_MSB:0];
         end
         else if (wr_sel == VRS_SEL_CMP)
         begin
            ctrl[VRS_SRC_CMP].keep_on      <= w_byte[VRS_KEEP_ON_BIT];
            ctrl[VRS_SRC_CMP].level_select <= w_byte[VRS_LEVEL_MSB:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // Read channel
   // ---------------------------------------------------------------
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_sel        = decode_sel(s_axi_araddr);

   always_comb
   begin
      next_rdata = 32'h0000_0000;
      if (rd_sel == VRS_SEL_IN)
         next_rdata[7:0] = ctrl[VRS_SRC_IN];
      else if (rd_sel == VRS_SEL_OUT)
         next_rdata[7:0] = ctrl[VRS_SRC_OUT];
      else if (rd_sel == VRS_SEL_CMP)
         next_rdata[7:0] = ctrl[VRS_SRC_CMP];
      else if (rd_sel == VRS_SEL_STAT)
      begin
         next_rdata[VRS_NUM_SRC-1:0] = {route[VRS_SRC_CMP].enable,
                                        route[VRS_SRC_OUT].enable,
                                        route[VRS_SRC_IN].enable};
         next_rdata[VRS_STAT_REQ_LSB +: VRS_NUM_SRC] = request;
      end
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= VRS_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= next_rdata;
         if (rd_sel == VRS_SEL_NONE)
            s_axi_rresp <= VRS_RESP_SLVERR;
         else
            s_axi_rresp <= VRS_RESP_OKAY;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // ---------------------------------------------------------------
   // Reference sources
   // ---------------------------------------------------------------
   // Each source sees only its own register and request, so no
   // keep-on bit can reach a neighbouring source.
   for (genvar i = 0; i < VRS_NUM_SRC; i++)
   begin : g_src
      vrs_ref_channel u_channel
      (
         .mclk    (mclk),
         .reset_n (reset_n),
         .ctrl    (ctrl[i]),
         .request (request[i]),
         .route   (route[i])
      );
   end

   assign converter_input_ref  = route[VRS_SRC_IN];
   assign converter_output_ref = route[VRS_SRC_OUT];
   assign comparators_ref      = route[VRS_SRC_CMP];

endmodule

/* File: verif/vrs_regs_asserts.sv */
// Port checker for the reference-select register bank
module vrs_regs_asserts
   import vrs_pkg::*;
(
   // Clock and reset
   input wire logic        mclk,
   input wire logic        reset_n,
   // Register bus
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // Requests and routes
   input wire logic        converter_input_req,
   input wire logic        converter_output_req,
   input wire logic        comparators_req,
   input vrs_route_t       converter_input_ref,
   input vrs_route_t       converter_output_ref,
   input vrs_route_t       comparators_ref
);
   // --------------------
   // Properties
   // --------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   // Reserved codes skipped: their routing is left open
   property decode_ok(vrs_route_t q);
      $past(reset_n) && !(q.level_select inside {3'h4, 3'h7}) |->
         q.internal == (q.level_select < 3'h4) &&
         q.supply == (q.level_select == 3'h5) &&
         q.external_ref_pin == (q.level_select == 3'h6);
   endproperty
   property on_request(logic want, logic on);
      want |=> on;
   endproperty

   chk_write_answer:
      assert property (wr_taken |-> ##2 s_axi_bvalid)
      else $error("write response missing");
   chk_bresp_held:
      assert property (s_axi_bvalid && !s_axi_bready |=>
         s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   chk_read_answer:
      assert property (rd_taken |=> s_axi_rvalid &&
         (s_axi_rdata & ($past(s_axi_araddr[7:2]) == VRS_IDX_STATUS ?
         32'hFFFFFF88 : 32'hFFFFFF78)) == 32'h0)
      else $error("read answer late or unused bits set");
   chk_rdata_held:
      assert property (s_axi_rvalid && !s_axi_rready |=>
         s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   chk_in_on_req:
      assert property (on_request(converter_input_req,
         converter_input_ref.enable)) else $error("input source off");
   chk_out_on_req:
      assert property (on_request(converter_output_req,
         converter_output_ref.enable)) else $error("output source off");
   chk_cmp_on_req:
      assert property (on_request(comparators_req,
         comparators_ref.enable)) else $error("comparator source off");
   chk_in_drop_idle:
      assert property ($fell(converter_input_ref.enable) |->
         !$past(converter_input_req)) else $error("source dropped early");
   chk_in_decode:
      assert property (decode_ok(converter_input_ref))
      else $error("input routing wrong");
   chk_out_decode:
      assert property (decode_ok(converter_output_ref))
      else $error("output routing wrong");
   chk_cmp_decode:
      assert property (decode_ok(comparators_ref))
      else $error("comparator routing wrong");
endmodule

bind vrs_regs vrs_regs_asserts chk_u (.mclk, .reset_n, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
   .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
   .converter_input_req, .converter_output_req, .comparators_req,
   .converter_input_ref,
   .converter_output_ref, .comparators_ref);

/* File: verif/vrs_consumers.sv */
// Consumers that request the three reference sources
module vrs_consumers
(
   // Clock and reset
   input wire logic        mclk,
   input wire logic        reset_n,
   // Pattern from the bench
   input wire logic [2:0]  want,
   input wire logic        jitter,
   // Requests, level held while in use
   output logic [2:0]      req
);
   timeunit 1ns;
   timeprecision 1ns;
   integer seed = 32'h918C;
   // Jitter draws a random request pattern every cycle to catch late enables
   always @(posedge mclk or negedge reset_n)
      if (!reset_n)
         req <= 3'h0;
      else
         req <= jitter ? 3'($random(seed)) : want;
endmodule

/* File: verif/vrs_regs_test.sv */
// Self-checking bench of the reference-select register bank
module vrs_regs_test
   import vrs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk, reset_n, jitter, s_axi_awvalid, s_axi_wvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awready;
   logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [2:0]  req, want, prev;
   logic [7:0]  shadow [3];
   vrs_route_t  converter_input_ref, converter_output_ref, comparators_ref;
   integer      err_count, compares, seed;

   vrs_regs #(.ADDR_W(8)) dut_u (.mclk, .reset_n, .s_axi_awvalid,
      .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid,
      .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
      .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
      .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready,
      .s_axi_rdata, .s_axi_rresp, .converter_input_req(req[0]),
      .converter_output_req(req[1]), .comparators_req(req[2]),
      .converter_input_ref, .converter_output_ref, .comparators_ref);
   vrs_consumers part_u (.mclk, .reset_n, .want, .jitter, .req);

   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // --------------------
   // Expectation and checks
   // --------------------
   function automatic vrs_route_t exp_route(logic [7:0] c, logic q);
      exp_route = {c[7] | q, c[2:0], c[2:0] < 3'h4, c[2:0] == 3'h5,
         c[2:0] == 3'h6};
   endfunction
   // Status word: enables in bits 2:0, raw requests in bits 6:4
   function automatic logic [31:0] exp_status(logic [2:0] q);
      exp_status = {25'h0, q, 1'b0, shadow[2][7] | q[2],
         shadow[1][7] | q[1], shadow[0][7] | q[0]};
   endfunction
   task automatic cmp(logic [31:0] got, logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Reserved codes: only enable and stored level are compared
   task automatic cmp_route(vrs_route_t got, vrs_route_t exp);
      logic [6:0] m;
      m = exp.level_select inside {3'h4, 3'h7} ? 7'h78 : 7'h7F;
      cmp({25'h0, got & m}, {25'h0, exp & m});
   endtask
   task automatic routes(logic [2:0] q);
      cmp_route(converter_input_ref, exp_route(shadow[0], q[0]));
      cmp_route(converter_output_ref, exp_route(shadow[1], q[1]));
      cmp_route(comparators_ref, exp_route(shadow[2], q[2]));
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] v, logic [3:0] s);
      @(posedge mclk);
      s_axi_awvalid <= 1'b1;
      s_axi_awaddr <= a;
      s_axi_wvalid <= 1'b1;
      s_axi_wdata <= v;
      s_axi_wstrb <= s;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge mclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      r = s_axi_bresp;
   endtask
   task automatic rd(logic [7:0] a);
      @(posedge mclk);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr <= a;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge mclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask
   // Three edges: consumer latch, then one-cycle route lag
   task automatic check_all(string name);
      repeat (3) @(posedge mclk);
      routes(req);
      for (int i = 0; i < 3; i++)
      begin
         rd(8'(i * 8));
         cmp(d, {24'h0, shadow[i]});
         cmp({30'h0, r}, 32'h0);
      end
      rd(8'h18);
      cmp(d, exp_status(req));
      cmp({30'h0, r}, 32'h0);
      $display("test %s done", name);
   endtask
   task automatic give_verdict;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // --------------------
   // Sequence and watchdog
   // --------------------
   initial
   begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready, reset_n, jitter, want} = 7'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
      err_count = 0;
      compares = 0;
      seed = 32'h918C;
      shadow = '{8'h00, 8'h00, 8'h00};
      repeat (6) @(posedge mclk);
      reset_n <= 1'b1;
      check_all("reset");
      for (int c = 0; c < 8; c++)
         for (int i = 0; i < 3; i++)
         begin
            d = $random(seed);
            d[2:0] = 3'(c);
            wr(8'(i * 8), d, 4'h1);
            cmp({30'h0, r}, 32'h0);
            shadow[i] = d[7:0] & 8'h87;
            want <= 3'($random(seed));
            check_all("code");
         end
      wr(8'h00, 32'h0000_0085, 4'hE);
      cmp({30'h0, r}, 32'h0);
      for (int k = 0; k < 3; k++)
      begin
         wr(8'h04 + 8'(k * 20), 32'h0000_00FF, 4'hF);
         cmp({30'h0, r}, 32'h2);
      end
      rd(8'h04);
      cmp(d, 32'h0);
      cmp({30'h0, r}, 32'h2);
      check_all("refused");
      jitter <= 1'b1;
      @(posedge mclk);
      prev = req;
      for (int n = 0; n < 64; n++)
      begin
         @(posedge mclk);
         routes(prev);
         prev = req;
      end
      $display("test jitter done");
      give_verdict;
   end

   initial
   begin
      repeat (5000) @(posedge mclk);
      err_count++;
      give_verdict;
   end
endmodule
